// ===== rtl/cfi_fifo_int.sv
// APB register block holding the interrupt enables and status flags of the CAN message FIFOs.
// Assumes level strobes from the FIFO logic (direction, full, half, empty) and a
// one-cycle receive-overflow pulse, all synchronous to pclk.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module cfi_fifo_int
    import cfi_pkg::*;
#(
    parameter int NUM_FIFOS = 32
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_FIFOS-1:0] fifo_direction_transmit,
    input  wire logic [NUM_FIFOS-1:0] fifo_full,
    input  wire logic [NUM_FIFOS-1:0] fifo_half,
    input  wire logic [NUM_FIFOS-1:0] fifo_empty,
    input  wire logic [NUM_FIFOS-1:0] rx_message_dropped,
    output logic      [NUM_FIFOS-1:0] fifo_irq
);

    localparam int IDX_W = $clog2(NUM_FIFOS);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [6:0]           enable_reg   [NUM_FIFOS];
    logic [6:0]           enable_next  [NUM_FIFOS];
    logic [NUM_FIFOS-1:0] overflow_reg;
    logic [NUM_FIFOS-1:0] overflow_next;
    logic [NUM_FIFOS-1:0] irq_reg;
    logic [NUM_FIFOS-1:0] irq_next;
    logic [31:0]          prdata_reg;
    logic [31:0]          prdata_next;
    logic                 pready_reg;
    logic                 pready_next;
    logic                 pslverr_reg;
    logic                 pslverr_next;

    logic                 hit;
    logic [IDX_W-1:0]     idx;
    logic                 access;
    logic                 commit;
    logic [NUM_FIFOS-1:0] sel;
    logic [31:0]          word         [NUM_FIFOS];

    // Enable byte 2 holds bits 19..16, byte 3 bits 26..24.
    function automatic logic [31:0] word_of(input logic [6:0] en, input logic tx,
                                            input logic full, input logic half,
                                            input logic empty, input logic ovf);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CFI_TX_NOT_FULL_EN_BIT]  = en[6];
        w[CFI_TX_HALF_EN_BIT]      = en[5];
        w[CFI_TX_EMPTY_EN_BIT]     = en[4];
        w[CFI_RX_OVERFLOW_EN_BIT]  = en[3];
        w[CFI_RX_FULL_EN_BIT]      = en[2];
        w[CFI_RX_HALF_EN_BIT]      = en[1];
        w[CFI_RX_NOT_EMPTY_EN_BIT] = en[0];
        w[CFI_TX_NOT_FULL_BIT]     = tx & ~full;
        w[CFI_TX_HALF_BIT]         = tx & half;
        w[CFI_TX_EMPTY_BIT]        = tx & empty;
        w[CFI_RX_OVERFLOW_BIT]     = ~tx & ovf;
        w[CFI_RX_FULL_BIT]         = ~tx & full;
        w[CFI_RX_HALF_BIT]         = ~tx & half;
        w[CFI_RX_NOT_EMPTY_BIT]    = ~tx & ~empty;
        return w;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // FIFO n sits at byte offset n*4 above the base; a misaligned address hits nothing.
    assign idx    = paddr[IDX_W+1:2];
    assign hit    = (paddr[1:0] == 2'b00) && (paddr >= CFI_INT_BASE)
                    && ((paddr - CFI_INT_BASE) < 12'(NUM_FIFOS * 4));

    // The first access cycle raises pready for exactly one cycle.
    assign access = psel && penable && !pready_reg;

    // The master samples pready high at the end of this cycle. A write lands only
    // here, so an access that never completes leaves every register untouched.
    assign commit = psel && penable && pready_reg;

    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            sel[i] = hit && (idx == IDX_W'(i));
        end
    end

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    // The level flags are decoded straight from the FIFO inputs on every cycle and
    // have no storage of their own, so software can never overwrite them.
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            word[i] = word_of(enable_reg[i], fifo_direction_transmit[i], fifo_full[i],
                              fifo_half[i], fifo_empty[i], overflow_reg[i]);
        end
    end

    // ------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------
    // Each enable group follows its own byte strobe, so a partial write from
    // software leaves the other group as it was.
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            enable_next[i] = enable_reg[i];
            if (commit && pwrite && sel[i] && pstrb[3]) begin
                enable_next[i][6:4] = pwdata[CFI_TX_EMPTY_EN_BIT +: 3];
            end
            if (commit && pwrite && sel[i] && pstrb[2]) begin
                enable_next[i][3:0] = pwdata[CFI_RX_NOT_EMPTY_EN_BIT +: 4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_FIFOS; i++) begin
                enable_reg[i] <= CFI_ENABLE_RESET;
            end
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ------------------------------------------------------------
    // Receive overflow flags
    // ------------------------------------------------------------
    // A clear needs a zero in bit 3 under its byte strobe. The set is applied last,
    // so a message lost in the very cycle of a clear is still reported.
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            overflow_next[i] = overflow_reg[i];
            if (commit && pwrite && sel[i] && pstrb[0] && !pwdata[CFI_RX_OVERFLOW_BIT]) begin
                overflow_next[i] = 1'b0;
            end
            if (rx_message_dropped[i] && !fifo_direction_transmit[i]) begin
                overflow_next[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_reg <= {NUM_FIFOS{CFI_OVERFLOW_RESET}};
        end else begin
            overflow_reg <= overflow_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    // Each enable sits 16 bits above its flag. The request is registered, so it
    // trails the level inputs by one cycle and a dropped message by two, but never glitches.
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            irq_next[i] = (|(word[i][CFI_TX_EMPTY_EN_BIT +: 3]
                             & word[i][CFI_TX_EMPTY_BIT +: 3]))
                          || (|(word[i][CFI_RX_NOT_EMPTY_EN_BIT +: 4]
                                & word[i][CFI_RX_NOT_EMPTY_BIT +: 4]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------
    // One wait state: the reply is registered on the first access cycle and held
    // for exactly one cycle. Read data of a refused access stays zero.
    always_comb begin
        pready_next  = access;
        pslverr_next = access && !hit;
        prdata_next  = 32'h0000_0000;
        for (int i = 0; i < NUM_FIFOS; i++) begin
            if (access && !pwrite && sel[i]) begin
                prdata_next = word[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign fifo_irq = irq_reg;

endmodule

`default_nettype wire

// ===== rtl/cfi_pkg.sv
// Constants for the per-FIFO interrupt enable and status block of a CAN controller.
// Assumes an APB slave port on pclk and FIFO status strobes from the CAN core on the same clock.
package cfi_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // One word per FIFO, FIFO n at byte offset n*4.
    localparam logic [11:0] CFI_INT_BASE = 12'h000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFI_TX_NOT_FULL_EN_BIT = 26;
    localparam int CFI_TX_HALF_EN_BIT     = 25;
    localparam int CFI_TX_EMPTY_EN_BIT    = 24;
    localparam int CFI_RX_OVERFLOW_EN_BIT = 19;
    localparam int CFI_RX_FULL_EN_BIT     = 18;
    localparam int CFI_RX_HALF_EN_BIT     = 17;
    localparam int CFI_RX_NOT_EMPTY_EN_BIT = 16;
    localparam int CFI_TX_NOT_FULL_BIT    = 10;
    localparam int CFI_TX_HALF_BIT        = 9;
    localparam int CFI_TX_EMPTY_BIT       = 8;
    localparam int CFI_RX_OVERFLOW_BIT    = 3;
    localparam int CFI_RX_FULL_BIT        = 2;
    localparam int CFI_RX_HALF_BIT        = 1;
    localparam int CFI_RX_NOT_EMPTY_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] CFI_ENABLE_RESET   = 7'h00;
    localparam logic       CFI_OVERFLOW_RESET = 1'b0;

endpackage

// ===== tb/cfi_fifo_int_props.sv
// Checker for the FIFO interrupt register block.
// Assumes it is bound to cfi_fifo_int.
`timescale 1ns/1ns
`default_nettype none
module cfi_fifo_int_props #(
    parameter int NUM_FIFOS = 32
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [NUM_FIFOS-1:0] fifo_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("late pready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("long pready");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("stray pready");
    a_idle_quiet: assert property (!psel |=> !pready)
        else $error("pready idle");
    a_unused_zero: assert property (pready |-> (prdata & 32'hf8f0f800) == 32'h0)
        else $error("unused bits set");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    a_err_decode: assert property (pready |-> pslverr == (paddr >= 12'(NUM_FIFOS * 4) || paddr[1:0] != 2'b00))
        else $error("bad decode");
    a_reset_quiet: assert property ($rose(presetn) |-> !pready && fifo_irq == 0)
        else $error("not quiet after reset");
    cover property (pslverr);
    cover property (pready && prdata[3]);
    cover property (|fifo_irq);
endmodule
bind cfi_fifo_int cfi_fifo_int_props #(.NUM_FIFOS(NUM_FIFOS)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_irq(fifo_irq));
`default_nettype wire

// ===== tb/cfi_fifo_int_test.sv
// Random register test of the FIFO interrupt block.
// Assumes direction stays fixed per FIFO during the run.
`timescale 1ns/1ns
`default_nettype none
module cfi_fifo_int_test;
    import cfi_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [3:0]  pstrb = 0, s;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, d, irq, ovf = 0;
    logic [31:0] dir = 0, full = 0, half = 0, empty = 0, drop = 0;
    logic [31:0] en [32];
    int          seed = 32'hef29f995, fail_count = 0, n_tests = 0, k;
    always #4 pclk = ~pclk;
    cfi_fifo_int dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_direction_transmit(dir), .fifo_full(full),
        .fifo_half(half), .fifo_empty(empty), .rx_message_dropped(drop), .fifo_irq(irq));
    function automatic logic [31:0] expw(int n);
        return en[n] | (dir[n] ? {21'h0, !full[n], half[n], empty[n], 8'h0}
            : {28'h0, ovf[n], full[n], half[n], !empty[n]});
    endfunction
    task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s: expected %h, seen %h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(int n);
        apb(0, 12'(n * 4), 0, 4'h0);
        chk("word", r, expw(n));
        chk("rd err", 32'(err), 0);
        chk("irq", 32'(irq[n]), 32'(|((expw(n) >> 16) & expw(n) & 32'h070f)));
    endtask
    task conclude;
        $display("comparisons %0d, errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        conclude;
    end
    initial begin
        en = '{default: 0};
        repeat (3) @(posedge pclk);
        presetn <= 1;
        // FIFO 0 always receives, for the overflow corner case below.
        dir <= $random(seed) & ~32'h1;
        full <= $random(seed);
        @(posedge pclk);
        for (k = 0; k < 32; k++) rd(k);
        repeat (80) begin
            k = $unsigned($random(seed)) % 32;
            d = $random(seed);
            s = 4'($random(seed));
            apb(1, 12'(k * 4), d, s);
            if (s[3]) en[k][26:24] = d[26:24];
            if (s[2]) en[k][19:16] = d[19:16];
            if (s[0] && !d[3]) ovf[k] = 0;
            full <= $random(seed);
            half <= $random(seed);
            empty <= $random(seed);
            @(posedge pclk);
            drop <= full & ~dir & $random(seed);
            @(posedge pclk);
            ovf |= drop & ~dir;
            drop <= 0;
            @(posedge pclk);
            rd(k);
        end
        // A lost message in the very cycle of a clearing write must win.
        fork
            apb(1, 12'h000, 0, 4'hf);
            begin
                repeat (2) @(posedge pclk);
                drop <= 32'h1;
                @(posedge pclk);
                drop <= 0;
            end
        join
        en[0] = 0;
        ovf[0] = 1;
        rd(0);
        apb(1, 12'hffc, '1, 4'hf);
        chk("err", 32'(err), 1);
        apb(0, 12'h006, 0, 4'h0);
        chk("err", 32'(err), 1);
        chk("err data", r, 0);
        rd(31);
        // A second reset in mid-run must clear every enable and overflow flag.
        presetn <= 0;
        en = '{default: 0};
        ovf = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (k = 0; k < 32; k++) rd(k);
        conclude;
    end
endmodule
`default_nettype wire
